/* design/msf_top.sv */
// Local design decision: strobed register access.
`default_nettype none
module msf_top
  import msf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       conv_end,
  input  wire logic       amp_bypassed,
  input  wire logic       amp_pos_high,
  input  wire logic       amp_pos_low,
  input  wire logic       amp_neg_high,
  input  wire logic       amp_neg_low,
  input  wire logic       adc_pos_high,
  input  wire logic       adc_pos_low,
  input  wire logic       adc_neg_high,
  input  wire logic       adc_neg_low,
  input  wire logic       ref_below_low,
  input  wire logic       ref_below_third,
  output logic            conversion_done_out_n,
  output logic            prepend_status,
  output logic      [7:0] prepend_byte,
  output logic      [2:0] path_source,
  output logic            inputs_connected,
  output logic      [2:0] effective_gain,
  output logic            burnout_sources,
  output logic      [1:0] burnout_level,
  output logic      [3:0] excitation_magnitude,
  output logic      [3:0] source_one_pin_select,
  output logic      [3:0] source_two_pin_select,
  output logic            bias_level_select,
  output logic      [6:0] bias_pin_enables,
  output logic            rail_monitor_active
);
  localparam int CW = $clog2(MSF_INIT_CYCLES + 1);

  logic [7:0]    gain_r;
  logic [7:0]    refctl_r;
  logic [7:0]    exc1_r;
  logic [7:0]    exc2_r;
  logic [7:0]    bias_r;
  logic [7:0]    sysctl_r;
  logic          por_flag_r;
  logic [CW-1:0] init_cnt_r;
  logic          ready_r;
  logic [3:0]    rail_live;
  logic [5:0]    faults;
  logic [7:0]    status;
  msf_mon_t      mon;

  // supply monitor codes override the gain field
  function automatic logic is_supply(input msf_mon_t m);
    return (m == MSF_MON_AVDD) || (m == MSF_MON_DVDD);
  endfunction

  function automatic logic is_burnout(input msf_mon_t m);
    return (m == MSF_MON_BO_LO) || (m == MSF_MON_BO_MD) || (m == MSF_MON_BO_HI);
  endfunction

  assign mon       = msf_mon_t'(sysctl_r[2:0]);

  // start-up needs at least one cycle; control bits must sit where the
  // slices below expect them, since bias enables take bits 6..0
  if (MSF_INIT_CYCLES < 1) begin
    $error("msf_top: start-up count must be positive");
  end
  if (MSF_SYSCTL_PREPEND > 7 || MSF_EXC1_FLT_EN > 7 || MSF_BIAS_LEVEL != 7) begin
    $error("msf_top: control bit position does not fit its register");
  end
  // the status word is a plain concatenation, so the flag order is fixed
  if (MSF_BIT_POR != 7 || MSF_BIT_RDY != 6 || MSF_BIT_REF_LOW != 0) begin
    $error("msf_top: status layout differs from its concatenation");
  end

  // configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_r   <= MSF_RST_GAIN;
      refctl_r <= MSF_RST_REFCTL;
      exc1_r   <= MSF_RST_EXC1;
      exc2_r   <= MSF_RST_EXC2;
      bias_r   <= MSF_RST_BIAS;
      sysctl_r <= MSF_RST_SYSCTL;
    end else if (wr) begin
      case (addr)
        MSF_ADDR_GAIN:   gain_r   <= wdata;
        MSF_ADDR_REFCTL: refctl_r <= wdata;
        MSF_ADDR_EXC1:   exc1_r   <= wdata;
        MSF_ADDR_EXC2:   exc2_r   <= wdata;
        MSF_ADDR_BIAS:   bias_r   <= wdata;
        MSF_ADDR_SYSCTL: sysctl_r <= wdata;
        default: ;
      endcase
    end
  end

  // power-on flag: only a written zero clears it, a one is ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_flag_r <= 1'b1;
    end else if (wr && addr == MSF_ADDR_STATUS && !wdata[MSF_BIT_POR]) begin
      por_flag_r <= 1'b0;
    end
  end

  // start-up counter; the map is considered settled after it expires
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_cnt_r <= '0;
      ready_r    <= 1'b0;
    end else if (init_cnt_r != CW'(MSF_INIT_CYCLES)) begin
      init_cnt_r <= init_cnt_r + CW'(1);
    end else begin
      ready_r <= 1'b1;
    end
  end

  // comparators follow the amplifier, or the converter input when bypassed
  always_comb begin
    if (amp_bypassed) begin
      rail_live = {adc_pos_high, adc_pos_low, adc_neg_high, adc_neg_low};
    end else begin
      rail_live = {amp_pos_high, amp_pos_low, amp_neg_high, amp_neg_low};
    end
  end

  // rail flags gated by 06h enable; reference flags by 05h enables
  msf_fault_latch #(
    .WIDTH(4)
  ) u_rail (
    .clk      (clk),
    .rstn     (rstn),
    .enable   (exc1_r[MSF_EXC1_FLT_EN]),
    .live     (rail_live),
    .conv_end (conv_end),
    .latched  (faults[5:2])
  );

  msf_fault_latch #(
    .WIDTH(2)
  ) u_ref (
    .clk      (clk),
    .rstn     (rstn),
    .enable   (refctl_r[0] | refctl_r[1]),
    .live     ({ref_below_third, ref_below_low}),
    .conv_end (conv_end),
    .latched  (faults[1:0])
  );

  // ready bit reads low when ready (active-low flag)
  assign status = {por_flag_r, ~ready_r, faults};

  // read port: data one cycle after strobe, zero when unmapped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        MSF_ADDR_STATUS: rdata <= status;
        MSF_ADDR_GAIN:   rdata <= gain_r;
        MSF_ADDR_REFCTL: rdata <= refctl_r;
        MSF_ADDR_EXC1:   rdata <= exc1_r;
        MSF_ADDR_EXC2:   rdata <= exc2_r;
        MSF_ADDR_BIAS:   rdata <= bias_r;
        MSF_ADDR_SYSCTL: rdata <= sysctl_r;
        default:         rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // data-ready style output: low for one cycle after a conversion end,
  // the same edge on which the flags move
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conversion_done_out_n <= 1'b1;
    end else begin
      conversion_done_out_n <= ~conv_end;
    end
  end

  // prepend enable follows the system control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prepend_status <= 1'b0;
    end else begin
      prepend_status <= sysctl_r[MSF_SYSCTL_PREPEND];
    end
  end

  // prepended status snapshot, taken at conversion end before the flags move
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prepend_byte <= 8'h00;
    end else if (conv_end) begin
      prepend_byte <= status;
    end
  end

  // measurement path routing from the monitor selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      path_source      <= MSF_SRC_INPUTS;
      inputs_connected <= 1'b1;
    end else begin
      case (mon)
        MSF_MON_TEMP: begin
          path_source      <= MSF_SRC_TEMP;
          inputs_connected <= 1'b0;
        end
        MSF_MON_AVDD: begin
          path_source      <= MSF_SRC_AVDD4;
          inputs_connected <= 1'b0;
        end
        MSF_MON_DVDD: begin
          path_source      <= MSF_SRC_DVDD4;
          inputs_connected <= 1'b0;
        end
        default: begin
          path_source      <= MSF_SRC_INPUTS;
          inputs_connected <= 1'b1;
        end
      endcase
    end
  end

  // gain follows the register except under a supply monitor, which always
  // measures at gain one; the temperature path keeps the programmed gain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      effective_gain <= 3'b000;
    end else begin
      effective_gain <= is_supply(mon) ? 3'b000 : gain_r[2:0];
    end
  end

  // burn-out sources: one sources into the positive input, one sinks
  // from the negative; a single enable drives both as a matched pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      burnout_sources <= 1'b0;
      burnout_level   <= 2'b00;
    end else begin
      burnout_sources <= is_burnout(mon);
      burnout_level   <= is_burnout(mon) ? (sysctl_r[1:0] - 2'b01) : 2'b00;
    end
  end

  // excitation settings; both sources may name the same pin, no check needed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      excitation_magnitude  <= MSF_RST_EXC1[3:0];
      source_one_pin_select <= MSF_RST_EXC2[3:0];
      source_two_pin_select <= MSF_RST_EXC2[7:4];
    end else begin
      excitation_magnitude  <= exc1_r[3:0];
      source_one_pin_select <= exc2_r[3:0];
      source_two_pin_select <= exc2_r[7:4];
    end
  end

  // bias generator level and per-pin enables
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bias_level_select <= 1'b0;
      bias_pin_enables  <= 7'h00;
    end else begin
      bias_level_select <= bias_r[MSF_BIAS_LEVEL];
      bias_pin_enables  <= bias_r[6:0];
    end
  end

  // rail monitor enable shown to the analogue side
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rail_monitor_active <= 1'b0;
    end else begin
      rail_monitor_active <= exc1_r[MSF_EXC1_FLT_EN];
    end
  end
endmodule
`default_nettype wire

/* design/msf_pkg.sv */
`default_nettype none
package msf_pkg;
  // register offsets
  localparam logic [7:0] MSF_ADDR_STATUS  = 8'h01;
  localparam logic [7:0] MSF_ADDR_GAIN    = 8'h03;
  localparam logic [7:0] MSF_ADDR_REFCTL  = 8'h05;
  localparam logic [7:0] MSF_ADDR_EXC1    = 8'h06;
  localparam logic [7:0] MSF_ADDR_EXC2    = 8'h07;
  localparam logic [7:0] MSF_ADDR_BIAS    = 8'h08;
  localparam logic [7:0] MSF_ADDR_SYSCTL  = 8'h09;
  // status bit positions
  localparam int MSF_BIT_POR       = 7;
  localparam int MSF_BIT_RDY       = 6;
  localparam int MSF_BIT_POS_HIGH  = 5;
  localparam int MSF_BIT_POS_LOW   = 4;
  localparam int MSF_BIT_NEG_HIGH  = 3;
  localparam int MSF_BIT_NEG_LOW   = 2;
  localparam int MSF_BIT_REF_THIRD = 1;
  localparam int MSF_BIT_REF_LOW   = 0;
  // field positions
  localparam int MSF_SYSCTL_PREPEND = 3;  // status_prepend_enable in 09h
  localparam int MSF_EXC1_FLT_EN    = 7;  // fault_monitor_enable in 06h
  localparam int MSF_BIAS_LEVEL     = 7;  // bias_level_select in 08h
  // reset values
  localparam logic [7:0] MSF_RST_GAIN   = 8'h00;
  localparam logic [7:0] MSF_RST_REFCTL = 8'h00;
  localparam logic [7:0] MSF_RST_EXC1   = 8'h00;
  localparam logic [7:0] MSF_RST_EXC2   = 8'hff;
  localparam logic [7:0] MSF_RST_BIAS   = 8'h00;
  localparam logic [7:0] MSF_RST_SYSCTL = 8'h00;
  // cycles the register map needs after reset before ready
  localparam int MSF_INIT_CYCLES = 16;
  // monitor selection codes
  typedef enum logic [2:0] {
    MSF_MON_OFF   = 3'b000,
    MSF_MON_RSVD  = 3'b001,
    MSF_MON_TEMP  = 3'b010,
    MSF_MON_AVDD  = 3'b011,
    MSF_MON_DVDD  = 3'b100,
    MSF_MON_BO_LO = 3'b101,
    MSF_MON_BO_MD = 3'b110,
    MSF_MON_BO_HI = 3'b111
  } msf_mon_t;
  // measurement path sources
  typedef enum logic [2:0] {
    MSF_SRC_INPUTS = 3'b000,
    MSF_SRC_TEMP   = 3'b001,
    MSF_SRC_AVDD4  = 3'b010,
    MSF_SRC_DVDD4  = 3'b011
  } msf_src_t;
endpackage
`default_nettype wire

/* design/msf_fault_latch.sv */
`default_nettype none
// accumulates comparator hits over one conversion, publishes at its end
module msf_fault_latch #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] live,
  input  wire logic             conv_end,
  output logic      [WIDTH-1:0] latched
);
  logic [WIDTH-1:0] acc_r;

  initial begin
    if (WIDTH < 1) $error("msf_fault_latch: WIDTH must be positive");
  end

  // sticky within a cycle; restart so a cleared fault drops next end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
    end else if (conv_end) begin
      acc_r <= '0;
    end else if (enable) begin
      acc_r <= acc_r | live;
    end
  end

  // published flags move only at a conversion end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latched <= '0;
    end else if (conv_end) begin
      latched <= enable ? (acc_r | live) : '0;
    end
  end
endmodule
`default_nettype wire

/* test/msf_top_asserts.sv */
`default_nettype none
// port-level checks on the status and monitor decode block
module msf_top_asserts (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       conv_end,
  input wire logic       conversion_done_out_n,
  input wire logic [7:0] prepend_byte,
  input wire logic [2:0] path_source,
  input wire logic       inputs_connected,
  input wire logic [2:0] effective_gain,
  input wire logic       burnout_sources,
  input wire logic [1:0] burnout_level,
  input wire logic [3:0] source_one_pin_select,
  input wire logic [3:0] source_two_pin_select
);
  import msf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic sys_wr;
  // decoded outputs land one edge after the write is taken and are checked at the second
  assign sys_wr = wr && addr == MSF_ADDR_SYSCTL;
  a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data seen outside its slot");
  a_done_pulse: assert property (conv_end |=> !conversion_done_out_n ##1 conversion_done_out_n)
    else $error("done output not a single low cycle");
  a_done_cause: assert property (!conversion_done_out_n |-> $past(conv_end))
    else $error("done output low without a conversion end");
  a_supply_gain: assert property (path_source inside {MSF_SRC_AVDD4, MSF_SRC_DVDD4}
    |-> effective_gain == 3'h0 && !inputs_connected)
    else $error("supply monitor without unity gain");
  a_temp_route: assert property (sys_wr && wdata[2:0] == 3'b010
    |-> ##2 path_source == MSF_SRC_TEMP && !inputs_connected)
    else $error("temperature sensor not routed");
  a_supply_sel: assert property (sys_wr && wdata[2:0] == 3'b011
    |-> ##2 path_source == MSF_SRC_AVDD4)
    else $error("analog supply monitor not routed");
  a_burnout_high: assert property (sys_wr && wdata[2:0] == 3'b111
    |-> ##2 burnout_sources && burnout_level == 2'h2)
    else $error("burn-out sources not at high level");
  a_snap_hold: assert property (!$past(conv_end) |-> $stable(prepend_byte))
    else $error("status snapshot moved between conversion ends");
  a_pin_copy: assert property (wr && addr == MSF_ADDR_EXC2
    |-> ##2 {source_two_pin_select, source_one_pin_select} == $past(wdata, 2))
    else $error("pin selects differ from written value");
  c_done: cover property (conv_end ##1 !conversion_done_out_n);
  c_temp: cover property (path_source == MSF_SRC_TEMP);
  c_burn: cover property (burnout_level == 2'h2);
endmodule
bind msf_top msf_top_asserts u_chk (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .conv_end(conv_end), .conversion_done_out_n(conversion_done_out_n),
  .prepend_byte(prepend_byte), .path_source(path_source),
  .inputs_connected(inputs_connected), .effective_gain(effective_gain),
  .burnout_sources(burnout_sources), .burnout_level(burnout_level),
  .source_one_pin_select(source_one_pin_select),
  .source_two_pin_select(source_two_pin_select)
);
`default_nettype wire

/* test/msf_host_model.sv */
`default_nettype none
// host controller: register master on the plain strobe bus
module msf_host_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle strobe, always a gap after, so no double drive per step
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data only stand in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import msf_pkg::*;
  logic clk = 1'b0;
  logic rstn, wr, rd, conv_end, done_n, pre_st, inp_on, bo_on, bias_lvl, rail_on;
  logic [7:0] addr, wdata, rdata, pre_byte, got, prev;
  logic [10:0] cmp;
  logic [2:0] path, gain, ps, g;
  logic [1:0] lvl, el;
  logic [3:0] mag, s1, s2;
  logic [6:0] bias_en;
  int errors = 0;
  int checks_done = 0;
  // bypass, amp ph pl nh nl, adc ph pl nh nl, ref third, ref low
  localparam logic [10:0] LIVE [8] = '{11'h200, 11'h100, 11'h080, 11'h040,
    11'h001, 11'h002, 11'h43c, 11'h7c0};
  localparam logic [7:0] EXP [8] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02, 8'h3c, 8'h00};
  always #50 clk = ~clk;
  msf_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  msf_top dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .conv_end(conv_end), .amp_bypassed(cmp[10]), .amp_pos_high(cmp[9]),
    .amp_pos_low(cmp[8]), .amp_neg_high(cmp[7]), .amp_neg_low(cmp[6]),
    .adc_pos_high(cmp[5]), .adc_pos_low(cmp[4]), .adc_neg_high(cmp[3]),
    .adc_neg_low(cmp[2]), .ref_below_third(cmp[1]), .ref_below_low(cmp[0]),
    .conversion_done_out_n(done_n), .prepend_status(pre_st), .prepend_byte(pre_byte),
    .path_source(path), .inputs_connected(inp_on), .effective_gain(gain),
    .burnout_sources(bo_on), .burnout_level(lvl), .excitation_magnitude(mag),
    .source_one_pin_select(s1), .source_two_pin_select(s2),
    .bias_level_select(bias_lvl), .bias_pin_enables(bias_en), .rail_monitor_active(rail_on)
  );
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset;
    host.read_reg(MSF_ADDR_STATUS, got);
    chk("status at start", 16'h00c0, {8'h00, got});
    chk("pin selects", 16'h00ff, {8'h00, s2, s1});
    repeat (MSF_INIT_CYCLES + 2) @(posedge clk);
    host.read_reg(MSF_ADDR_STATUS, got);
    chk("status ready", 16'h0080, {8'h00, got});
    host.write_reg(MSF_ADDR_STATUS, 8'hff);
    host.read_reg(MSF_ADDR_STATUS, got);
    chk("status after ones", 16'h0080, {8'h00, got});
    host.write_reg(MSF_ADDR_STATUS, 8'h00);
    host.read_reg(MSF_ADDR_STATUS, got);
    chk("status after zero", 16'h0000, {8'h00, got});
    $display("reset and flag clearing done");
  endtask
  // fault held two cycles then dropped before the end: must still latch
  task automatic conv(input logic [10:0] live, input logic [7:0] exp);
    @(posedge clk);
    cmp <= live;
    repeat (2) @(posedge clk);
    cmp <= {live[10], 10'h000};
    conv_end <= 1'b1;
    @(posedge clk);
    conv_end <= 1'b0;
    #1 chk("snapshot", {8'h00, prev}, {8'h00, pre_byte});
    host.read_reg(MSF_ADDR_STATUS, got);
    chk("latched status", {8'h00, exp}, {8'h00, got});
    prev = exp;
  endtask
  task automatic t_faults;
    host.write_reg(MSF_ADDR_REFCTL, 8'h03);
    host.write_reg(MSF_ADDR_EXC1, 8'h00);
    conv(11'h3c3, 8'h03);
    host.write_reg(MSF_ADDR_EXC1, 8'h80);
    for (int i = 0; i < 8; i++) conv(LIVE[i], EXP[i]);
    $display("fault latching done");
  endtask
  // gain two stays legal for temperature; a raised delay field must not leak
  task automatic t_monitor;
    host.write_reg(MSF_ADDR_GAIN, 8'he2);
    for (int c = 0; c < 8; c++) begin
      if (c == 1) continue;
      // upper control bits stay clear except bit 3 (prepend enable), so chop is off for burn-out codes
      host.write_reg(MSF_ADDR_SYSCTL, {5'h01, c[2:0]});
      repeat (2) @(posedge clk);
      ps = (c == 2) ? 3'h1 : (c == 3) ? 3'h2 : (c == 4) ? 3'h3 : 3'h0;
      g = (c == 3 || c == 4) ? 3'h0 : 3'h2;
      el = (c >= 5) ? 2'(c - 5) : 2'h0;
      chk("monitor decode", {5'h00, 1'b1, ps, ps == 3'h0, g, c >= 5, el},
        {5'h00, pre_st, path, inp_on, gain, bo_on, lvl});
    end
    $display("monitor selection done");
  endtask
  task automatic t_config;
    host.write_reg(MSF_ADDR_REFCTL, 8'h03);
    host.write_reg(MSF_ADDR_EXC1, 8'h8a);
    host.write_reg(MSF_ADDR_EXC2, 8'h33);
    host.write_reg(MSF_ADDR_BIAS, 8'hc1);
    repeat (2) @(posedge clk);
    chk("excitation", 16'h1a33, {3'h0, rail_on, mag, s2, s1});
    chk("bias", 16'h00c1, {8'h00, bias_lvl, bias_en});
    host.write_reg(8'h7e, 8'h5a);
    host.read_reg(8'h7e, got);
    chk("unmapped", 16'h0000, {8'h00, got});
    $display("configuration done");
  endtask
  initial begin
    rstn = 1'b0;
    conv_end = 1'b0;
    cmp = 11'h000;
    prev = 8'h00;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_faults;
    t_monitor;
    t_config;
    give_verdict;
  end
  // tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
